/* File: inc/fst_pkg.sv */
// constants and types shared by the feedthrough block
package fst_pkg;
    // ------------------------------------------------------------
    // host command decoding
    // ------------------------------------------------------------
    localparam logic [7:0] FST_OP_TEST_WRITE = 8'h24;
    localparam logic [7:0] FST_TEST_PASS = 8'h80;
    localparam logic [7:0] FST_TEST_RESET = 8'h00;
    localparam int FST_BYTE_BITS = 8;
    localparam int FST_FIFO_DEPTH = 16;
    localparam int FST_FIFO_WIDTH = 9;
    // ------------------------------------------------------------
    // pin reset levels and synchroniser width
    // ------------------------------------------------------------
    localparam logic FST_CS_IDLE = 1'b1;
    localparam logic FST_READY_IDLE = 1'b1;
    localparam int FST_SYNC_W = 5;
    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        FST_IDLE = 4'b0001,
        FST_OWN = 4'b0010,
        FST_PASS = 4'b0100,
        FST_READBACK = 4'b1000
    } fst_state_e;
endpackage : fst_pkg

/* File: rtl/fst_fifo.sv */
// byte fifo between the command shifter and the register writer
`timescale 1ns/1ps
module fst_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    a_fifo_no_overflow: assert property (@(posedge mclk) disable iff (srst)
        (wr_q - rd_q) <= (AW+1)'(DEPTH)) else $error("fifo overfilled");
endmodule : fst_fifo

/* File: rtl/fst_feedthrough.sv */
// memory feedthrough path between host spi and external memory
// What this block does
// - passthrough gives host exclusive memory use
// - own transaction finishes before host granted
// - ready goes low when passthrough usable
// - enter only with register 0x80 and request
// - request pin low ends passthrough
// - host select, clock, data copied to memory
// - memory data resampled onto host miso
// - passing bits never decoded or altered
// - entry request evaluated only in idle
// - on exit without brownout, read position back
`timescale 1ns/1ps
module fst_feedthrough import fst_pkg::*; (
    input wire logic mclk,
    input wire logic srst,
    input wire logic host_cs_n,
    input wire logic host_sck,
    input wire logic host_mosi,
    output logic host_miso,
    input wire logic passthrough_request_pin,
    output logic ready_pin,
    output logic memory_chip_select,
    output logic memory_serial_clock,
    output logic memory_data_out,
    input wire logic memory_data_in,
    input wire logic own_req,
    input wire logic own_cs_n,
    input wire logic own_sck,
    input wire logic own_mosi,
    output logic own_grant,
    output logic own_miso,
    input wire logic brownout_ok,
    output logic readback_start,
    input wire logic readback_done,
    output logic cmd_overrun
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [FST_SYNC_W-1:0] meta_q;
    logic [FST_SYNC_W-1:0] sync_q;
    logic sck_last_q;
    logic cs_n_s;
    logic sck_s;
    logic mosi_s;
    logic req_s;
    logic miso_s;

    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_q <= 5'h11;
            sync_q <= 5'h11;
            sck_last_q <= 1'b0;
        end else begin
            meta_q <= {memory_data_in, passthrough_request_pin, host_mosi, host_sck, host_cs_n};
            sync_q <= meta_q;
            sck_last_q <= sync_q[1];
        end
    end

    assign cs_n_s = sync_q[0];
    assign sck_s = sync_q[1];
    assign mosi_s = sync_q[2];
    assign req_s = sync_q[3];
    assign miso_s = sync_q[4];

    // ------------------------------------------------------------
    // command shifter (outside passthrough only)
    // ------------------------------------------------------------
    fst_state_e state_q;
    logic [7:0] shift_q;
    logic [2:0] bit_q;
    logic first_q;
    logic byte_valid_q;
    logic [8:0] byte_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [8:0] fifo_out_data;
    logic sck_rise;

    assign sck_rise = sck_s && !sck_last_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            shift_q <= 8'h00;
            bit_q <= 3'h0;
            first_q <= 1'b1;
            byte_valid_q <= 1'b0;
            byte_q <= 9'h000;
            cmd_overrun <= 1'b0;
        end else begin
            if (byte_valid_q && fifo_in_ready) begin
                byte_valid_q <= 1'b0;
            end
            if (cs_n_s || state_q == FST_PASS) begin
                bit_q <= 3'h0;
                first_q <= 1'b1;
            end else if (sck_rise) begin
                shift_q <= {shift_q[6:0], mosi_s};
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'(FST_BYTE_BITS - 1)) begin
                    first_q <= 1'b0;
                    if (byte_valid_q && !fifo_in_ready) begin
                        cmd_overrun <= 1'b1;
                    end else begin
                        byte_valid_q <= 1'b1;
                        byte_q <= {first_q, shift_q[6:0], mosi_s};
                    end
                end
            end
        end
    end

    fst_fifo #(
        .WIDTH(FST_FIFO_WIDTH),
        .DEPTH(FST_FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .srst(srst),
        .in_valid(byte_valid_q),
        .in_ready(fifo_in_ready),
        .in_data(byte_q),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------
    // test mode register writer
    // ------------------------------------------------------------
    logic [7:0] test_mode_register_q;
    logic expect_data_q;

    // register writes applied only while idle
    assign fifo_out_ready = state_q == FST_IDLE;

    always_ff @(posedge mclk) begin
        if (srst) begin
            test_mode_register_q <= FST_TEST_RESET;
            expect_data_q <= 1'b0;
        end else if (fifo_out_valid && fifo_out_ready) begin
            if (fifo_out_data[8]) begin
                expect_data_q <= fifo_out_data[7:0] == FST_OP_TEST_WRITE;
            end else begin
                expect_data_q <= 1'b0;
                if (expect_data_q) begin
                    test_mode_register_q <= fifo_out_data[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    logic enter_ok;

    assign enter_ok = req_s && test_mode_register_q == FST_TEST_PASS;

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= FST_IDLE;
        end else begin
            case (state_q)
                FST_IDLE: begin
                    if (enter_ok) begin
                        state_q <= FST_PASS;
                    end else if (own_req) begin
                        state_q <= FST_OWN;
                    end
                end
                FST_OWN: begin
                    if (!own_req) begin
                        state_q <= FST_IDLE;
                    end
                end
                FST_PASS: begin
                    if (!req_s) begin
                        state_q <= brownout_ok ? FST_READBACK : FST_IDLE;
                    end
                end
                FST_READBACK: begin
                    if (readback_done) begin
                        state_q <= FST_IDLE;
                    end
                end
                default: begin
                    state_q <= FST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            memory_chip_select <= FST_CS_IDLE;
            memory_serial_clock <= 1'b0;
            memory_data_out <= 1'b0;
            host_miso <= 1'b0;
            own_miso <= 1'b0;
            own_grant <= 1'b0;
            ready_pin <= FST_READY_IDLE;
            readback_start <= 1'b0;
        end else begin
            readback_start <= state_q == FST_PASS && !req_s && brownout_ok;
            ready_pin <= !(state_q == FST_PASS || state_q == FST_READBACK);
            own_grant <= state_q == FST_OWN || state_q == FST_READBACK;
            if (state_q == FST_PASS) begin
                memory_chip_select <= cs_n_s;
                memory_serial_clock <= sck_s;
                memory_data_out <= mosi_s;
                host_miso <= miso_s;
                own_miso <= 1'b0;
            end else if (state_q == FST_OWN || state_q == FST_READBACK) begin
                memory_chip_select <= own_cs_n;
                memory_serial_clock <= own_sck;
                memory_data_out <= own_mosi;
                host_miso <= 1'b0;
                own_miso <= miso_s;
            end else begin
                memory_chip_select <= FST_CS_IDLE;
                memory_serial_clock <= 1'b0;
                memory_data_out <= 1'b0;
                host_miso <= 1'b0;
                own_miso <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_pass_exclusive: assert property (@(posedge mclk) disable iff (srst)
        state_q == FST_PASS |=> !own_grant) else $error("own grant during passthrough");
    a_own_blocks_entry: assert property (@(posedge mclk) disable iff (srst)
        state_q == FST_OWN && own_req |=> state_q == FST_OWN) else $error("own access cut short");
    a_ready_low_pass: assert property (@(posedge mclk) disable iff (srst)
        $rose(state_q == FST_PASS) |=> !ready_pin) else $error("ready not low on entry");
    a_entry_needs_code: assert property (@(posedge mclk) disable iff (srst)
        state_q == FST_IDLE && !enter_ok |=> state_q != FST_PASS) else $error("entry without code");
    a_exit_on_low: assert property (@(posedge mclk) disable iff (srst)
        state_q == FST_PASS && !req_s |=> state_q != FST_PASS) else $error("passthrough held");
    a_forward_pins: assert property (@(posedge mclk) disable iff (srst)
        state_q == FST_PASS |=> memory_serial_clock == $past(sck_s) && memory_chip_select == $past(cs_n_s)
        && memory_data_out == $past(mosi_s)) else $error("host pins not forwarded");
    a_miso_resample: assert property (@(posedge mclk) disable iff (srst)
        state_q == FST_PASS |=> host_miso == $past(miso_s)) else $error("miso not resampled");
    a_no_decode_pass: assert property (@(posedge mclk) disable iff (srst)
        state_q == FST_PASS |=> $stable(test_mode_register_q)) else $error("register changed in passthrough");
    a_no_capture_pass: assert property (@(posedge mclk) disable iff (srst)
        state_q == FST_PASS |=> !$rose(byte_valid_q)) else $error("byte captured in passthrough");
    a_entry_from_idle: assert property (@(posedge mclk) disable iff (srst)
        $rose(state_q == FST_PASS) |-> $past(state_q) == FST_IDLE) else $error("entry outside idle");
    a_readback_exit: assert property (@(posedge mclk) disable iff (srst)
        state_q == FST_PASS && !req_s && brownout_ok |=> readback_start ##0 state_q == FST_READBACK)
        else $error("no readback on exit");
    c_enter_pass: cover property (@(posedge mclk) disable iff (srst) $rose(state_q == FST_PASS));
    c_exit_readback: cover property (@(posedge mclk) disable iff (srst) $rose(readback_start));
    c_own_then_pass: cover property (@(posedge mclk) disable iff (srst)
        state_q == FST_OWN ##1 state_q == FST_IDLE ##1 state_q == FST_PASS);
    c_fifo_stall: cover property (@(posedge mclk) disable iff (srst) byte_valid_q && !fifo_in_ready);
endmodule : fst_feedthrough

/* File: testbench/fst_host_model.sv */
// host spi master and external memory model
`timescale 1ns/1ps
module fst_host_model import fst_pkg::*; #(
    parameter int HALF = 4
) (
    input wire logic mclk,
    output logic host_cs_n,
    output logic host_sck,
    output logic host_mosi,
    input wire logic memory_chip_select,
    input wire logic memory_serial_clock,
    output logic memory_data_in
);
    logic sck_q = 1'b0;
    logic [7:0] mem_q = 8'ha5;
    initial begin
        host_cs_n = 1'b1;
        host_sck = 1'b0;
        host_mosi = 1'b0;
        memory_data_in = 1'b0;
    end
    // memory shifts out on falling clock, toggles when deselected
    always @(negedge mclk) begin
        sck_q <= memory_serial_clock;
        if (memory_chip_select) begin
            memory_data_in <= ~memory_data_in;
            mem_q <= 8'ha5;
        end else if (sck_q && !memory_serial_clock) begin
            memory_data_in <= mem_q[7];
            mem_q <= {mem_q[6:0], mem_q[7]};
        end
    end
    task automatic spi_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            host_mosi = b[i];
            repeat (HALF) @(negedge mclk);
            host_sck = 1'b1;
            repeat (HALF) @(negedge mclk);
            host_sck = 1'b0;
        end
    endtask : spi_byte
    // opcode then value under one select
    task automatic frame(input logic [7:0] op, input logic [7:0] v, input int extra);
        @(negedge mclk);
        host_cs_n = 1'b0;
        repeat (HALF) @(negedge mclk);
        spi_byte(op);
        spi_byte(v);
        repeat (extra) spi_byte(8'h00);
        repeat (HALF) @(negedge mclk);
        host_cs_n = 1'b1;
        host_mosi = ~host_mosi;
    endtask : frame
endmodule : fst_host_model

/* File: testbench/fst_feedthrough_tb.sv */
// self-checking bench for the memory feedthrough block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module fst_feedthrough_tb import fst_pkg::*; ();
    logic mclk = 1'b0, srst = 1'b1, passthrough_request_pin = 1'b0, own_req = 1'b0;
    logic brownout_ok = 1'b0, readback_done = 1'b0, own_cs_n = 1'b1, own_sck = 1'b0, own_mosi = 1'b0;
    logic host_cs_n, host_sck, host_mosi, host_miso, ready_pin, memory_chip_select, memory_serial_clock;
    logic memory_data_out, memory_data_in, own_grant, own_miso, readback_start, cmd_overrun, chk_on = 1'b0;
    logic [2:0] h_cs, h_sck, h_mosi, h_din;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    logic [7:0] row_val [4] = '{8'h7f, 8'h00, 8'h81, 8'h80};
    logic row_rdy [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    fst_feedthrough i_fst_feedthrough (.mclk, .srst, .host_cs_n, .host_sck, .host_mosi, .host_miso,
        .passthrough_request_pin, .ready_pin, .memory_chip_select, .memory_serial_clock, .memory_data_out,
        .memory_data_in, .own_req, .own_cs_n, .own_sck, .own_mosi, .own_grant, .own_miso, .brownout_ok,
        .readback_start, .readback_done, .cmd_overrun);
    fst_host_model i_fst_host_model (.mclk, .host_cs_n, .host_sck, .host_mosi, .memory_chip_select,
        .memory_serial_clock, .memory_data_in);
    always #25 mclk = ~mclk;
    // ------------------------------------------------------------
    // pin copy watch, three clocks behind
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        h_cs <= {h_cs[1:0], host_cs_n};
        h_sck <= {h_sck[1:0], host_sck};
        h_mosi <= {h_mosi[1:0], host_mosi};
        h_din <= {h_din[1:0], memory_data_in};
    end
    always @(negedge mclk) begin
        if (chk_on) begin
            `CHK("mem select", h_cs[2], memory_chip_select)
            `CHK("mem clock", h_sck[2], memory_serial_clock)
            `CHK("mem data", h_mosi[2], memory_data_out)
            `CHK("host miso", h_din[2], host_miso)
        end
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wait_rdy(input logic v);
        for (int i = 0; i < 16 && ready_pin !== v; i++) @(negedge mclk);
    endtask : wait_rdy
    task automatic enter_pass(input logic exp);
        passthrough_request_pin = 1'b1;
        wait_rdy(1'b0);
        `CHK("ready", exp, ready_pin)
        repeat (20) @(negedge mclk);
    endtask : enter_pass
    task automatic leave_pass;
        passthrough_request_pin = 1'b0;
        wait_rdy(1'b1);
        `CHK("ready", 1'b1, ready_pin)
    endtask : leave_pass
    task automatic traffic(input logic [7:0] v);
        repeat (6) @(negedge mclk);
        chk_on = 1'b1;
        i_fst_host_model.frame(FST_OP_TEST_WRITE, v, 1);
        chk_on = 1'b0;
    endtask : traffic
    initial begin
        repeat (8) @(negedge mclk);
        srst = 1'b0;
        `CHK("ready", FST_READY_IDLE, ready_pin)
        `CHK("mem select", FST_CS_IDLE, memory_chip_select)
        `CHK("readback", 1'b0, readback_start)
        $display("test reset done");
        for (int r = 0; r < 4; r++) begin
            i_fst_host_model.frame(FST_OP_TEST_WRITE, row_val[r], 0);
            repeat (10) @(negedge mclk);
            enter_pass(row_rdy[r]);
            if (row_rdy[r] == 1'b0) begin
                traffic(FST_TEST_RESET);
                traffic(FST_TEST_RESET);
            end
            leave_pass();
            $display("test row %0d done", r);
        end
        own_req = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK("grant", 1'b1, own_grant)
        own_cs_n = 1'b0;
        own_mosi = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK("own select", 1'b0, memory_chip_select)
        `CHK("own data", 1'b1, memory_data_out)
        `CHK("own miso", h_din[2], own_miso)
        own_cs_n = 1'b1;
        own_mosi = 1'b0;
        passthrough_request_pin = 1'b1;
        repeat (12) @(negedge mclk);
        `CHK("ready", 1'b1, ready_pin)
        own_req = 1'b0;
        wait_rdy(1'b0);
        `CHK("ready", 1'b0, ready_pin)
        own_req = 1'b1;
        repeat (8) @(negedge mclk);
        `CHK("grant", 1'b0, own_grant)
        traffic(8'hc3);
        own_req = 1'b0;
        $display("test own access done");
        brownout_ok = 1'b1;
        passthrough_request_pin = 1'b0;
        for (int i = 0; i < 8 && readback_start !== 1'b1; i++) @(negedge mclk);
        `CHK("readback", 1'b1, readback_start)
        @(negedge mclk);
        `CHK("readback", 1'b0, readback_start)
        `CHK("ready", 1'b0, ready_pin)
        `CHK("grant", 1'b1, own_grant)
        readback_done = 1'b1;
        @(negedge mclk);
        readback_done = 1'b0;
        brownout_ok = 1'b0;
        wait_rdy(1'b1);
        `CHK("ready", 1'b1, ready_pin)
        $display("test readback done");
        own_req = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK("overrun", 1'b0, cmd_overrun)
        i_fst_host_model.frame(FST_OP_TEST_WRITE, FST_TEST_RESET, 18);
        repeat (10) @(negedge mclk);
        `CHK("overrun", 1'b1, cmd_overrun)
        own_req = 1'b0;
        repeat (40) @(negedge mclk);
        enter_pass(1'b1);
        leave_pass();
        $display("test overrun done");
        own_req = 1'b1;
        repeat (4) @(negedge mclk);
        srst = 1'b1;
        own_req = 1'b0;
        repeat (3) @(negedge mclk);
        srst = 1'b0;
        `CHK("grant", 1'b0, own_grant)
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : fst_feedthrough_tb
